/* File: dv/fpsf_far_model.sv */
// Purpose: root-port side and eeprom loader seen from the power-state controller
// Assumes: one clock; loads start on a rising load request
// Notes:   completions return after a bench-set delay so entry to L1 can be stalled
`timescale 1ns/1ns
module fpsf_far_model
  import fpsf_pkg::*;
(
  // clock, reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  // from the device
  input  wire logic [2:0]                 link_req_i,
  input  wire logic                       eeprom_load_i,
  // bench control
  input  wire logic                       tlp_issue_i,
  input  wire logic [7:0]                 cpl_delay_i,
  // to the device
  output logic                            link_in_l0_o,
  output logic [FPSF_NUM_FUNC-1:0]        tlp_outstanding_o,
  output logic                            eeprom_busy_o,
  output logic                            eeprom_done_o
);
  import fpsf_pkg::*;
  logic [7:0] cpl_cnt_q;
  logic [3:0] ee_cnt_q;
  logic       load_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_in_l0_o      <= 1'b0;
      tlp_outstanding_o <= '0;
      cpl_cnt_q         <= 8'h00;
      ee_cnt_q          <= 4'h0;
      load_q            <= 1'b0;
      eeprom_busy_o     <= 1'b0;
      eeprom_done_o     <= 1'b0;
    end else begin
      // link follows the request one cycle late, as a retraining port would
      link_in_l0_o  <= (link_req_i == FPSF_LINK_L0);
      load_q        <= eeprom_load_i;
      eeprom_done_o <= 1'b0;
      if (tlp_issue_i) begin
        tlp_outstanding_o <= '1;
        cpl_cnt_q         <= cpl_delay_i;
      end else if (cpl_cnt_q != 8'h00) begin
        cpl_cnt_q <= cpl_cnt_q - 8'h01;
      end else begin
        tlp_outstanding_o <= '0;
      end
      if (eeprom_load_i && !load_q) begin
        eeprom_busy_o <= 1'b1;
        ee_cnt_q      <= 4'hA;
      end else if (eeprom_busy_o) begin
        ee_cnt_q <= ee_cnt_q - 4'h1;
        if (ee_cnt_q == 4'h1) begin
          eeprom_busy_o <= 1'b0;
          eeprom_done_o <= 1'b1;
        end
      end
    end
  end
endmodule // fpsf_far_model

/* File: dv/fpsf_top_bench.sv */
// Purpose: self-checking bench for the function power-state controller
// Assumes: four functions, outputs settle within four cycles of a strobe
// Notes:   expected states come from a per-function integer model
`timescale 1ns/1ns
module fpsf_top_bench;
  import fpsf_pkg::*;
  localparam int NF = FPSF_NUM_FUNC;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, clk_en_i = 1'b1, frst_n = 1'b0, aux = 1'b1;
  logic wake_ev = 1'b0, inband = 1'b0, err_en = 1'b0, cfg_msg = 1'b0, cpl = 1'b0, issue = 1'b0;
  logic [NF-1:0] rx_v = '0, pm_wr = '0, cmd_wr = '0;
  logic [1:0] pm_st = 2'h0;
  logic mem_en = 1'b0, io_en = 1'b0, pm_bit = 1'b1, apm_bit = 1'b0, mng = 1'b0;
  logic wc_wr = 1'b0, wc_apm = 1'b0, wf_wr = 1'b0;
  // completions must outlast all four d3 writes so the L1 hold-off is seen
  logic [7:0] wf = 8'h00, dly = 8'h40;
  logic l0, busy, done;
  logic [NF-1:0] outst;
  logic [1:0] dev_st;
  logic [2:0] link_req;
  logic link_en, ee_load, phy_rst, phy_low, ur, uc, err_msg, apm_en, wake_n, pm_dis;
  logic [NF-1:0] f_en, mio, m_en, sched, rx_disc;
  logic [7:0] wf_o;
  logic [4:0] seen;
  int error_cnt = 0, n_compared = 0, st[NF], seed_v;
  always #5 core_clk_i = ~core_clk_i;
  fpsf_far_model far (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link_req_i(link_req),
    .eeprom_load_i(ee_load), .tlp_issue_i(issue), .cpl_delay_i(dly), .link_in_l0_o(l0),
    .tlp_outstanding_o(outst), .eeprom_busy_o(busy), .eeprom_done_o(done));
  fpsf_top dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .fundamental_reset_n_i(frst_n), .aux_power_i(aux), .wake_event_i(wake_ev),
    .inband_reset_i(inband), .link_in_l0_i(l0), .tlp_rx_valid_i(rx_v),
    .tlp_is_cfg_msg_i(cfg_msg), .tlp_is_cpl_i(cpl), .err_report_en_i(err_en),
    .tlp_outstanding_i(outst), .pm_wr_i(pm_wr), .pm_state_i(pm_st), .cmd_wr_i(cmd_wr),
    .cmd_mem_en_i(mem_en), .cmd_io_en_i(io_en), .eeprom_busy_i(busy), .eeprom_done_i(done),
    .pm_enable_bit_i(pm_bit), .apm_wake_default_bit_i(apm_bit), .mng_or_wake_needed_i(mng),
    .wake_control_wr_i(wc_wr), .wake_control_apm_i(wc_apm), .wake_filter_control_wr_i(wf_wr),
    .wake_filter_control_i(wf), .device_state_o(dev_st), .link_req_o(link_req),
    .link_enable_o(link_en), .eeprom_load_o(ee_load), .phy_reset_o(phy_rst),
    .phy_low_speed_o(phy_low), .func_enable_o(f_en), .mem_io_en_o(mio), .master_en_o(m_en),
    .tlp_sched_en_o(sched), .rx_discard_o(rx_disc), .ur_o(ur), .uc_o(uc), .err_msg_o(err_msg),
    .apm_wake_en_o(apm_en), .wake_filter_o(wf_o), .sideband_wake_request_n_o(wake_n),
    .pm_disabled_o(pm_dis));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
  // expected summary: any D0 sub-state wins over D3hot, which wins over reset-held
  function automatic logic [1:0] exp_dev();
    logic [1:0] r;
    r = FPSF_DEV_RST;
    for (int f = 0; f < NF; f++) begin
      if (st[f] == 1 || st[f] == 2) r = FPSF_DEV_D0;
      else if (st[f] == 3 && r == FPSF_DEV_RST) r = FPSF_DEV_D3H;
    end
    return r;
  endfunction
  function automatic logic [NF-1:0] act_mask();
    logic [NF-1:0] m;
    for (int f = 0; f < NF; f++) m[f] = (st[f] == 2);
    return m;
  endfunction
  task automatic pm_write(input int f, input logic [1:0] ps);
    @(posedge core_clk_i);
    pm_wr <= NF'(1 << f);
    pm_st <= ps;
    @(posedge core_clk_i);
    pm_wr <= '0;
    if (ps == FPSF_PS_D3 && st[f] != 3 && pm_bit) st[f] = 3;
    else if (ps == FPSF_PS_D0 && st[f] == 3) st[f] = 1;
    settle();
  endtask
  task automatic cmd_write(input int f, input logic m, input logic io);
    @(posedge core_clk_i);
    cmd_wr <= NF'(1 << f);
    mem_en <= m;
    io_en  <= io;
    @(posedge core_clk_i);
    cmd_wr <= '0;
    if (st[f] == 1) st[f] = 2;
    settle();
  endtask
  task automatic watch(input int n);
    seen = '0;
    // starts on the strobe's edge so one-cycle pulses launched there are caught
    repeat (n) begin
      #1;
      seen = seen | {link_req == FPSF_LINK_L0, err_msg, uc, ur, |rx_disc};
      @(posedge core_clk_i);
    end
    #1;
  endtask
  task automatic boot(input logic pmb);
    int k;
    @(posedge core_clk_i);
    pm_bit <= pmb;
    frst_n <= 1'b1;
    for (k = 0; k < 50 && busy !== 1'b1; k++) @(posedge core_clk_i);
    #1;
    chk(phy_rst, 1'b1);
    chk(link_en, 1'b0);
    for (k = 0; k < 50 && done !== 1'b1; k++) @(posedge core_clk_i);
    settle();
    for (int f = 0; f < NF; f++) st[f] = 1;
    chk(link_en, 1'b1);
    chk(dev_st, exp_dev());
    chk(apm_en, apm_bit);
    chk(wf_o, 8'h00);
    chk(pm_dis, !pmb);
  endtask
  task automatic close_out();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk_i);
    error_cnt++;
    close_out();
  end
  initial begin
    seed_v = $urandom(32'h5105);
    for (int f = 0; f < NF; f++) st[f] = 0;
    repeat (3) @(posedge core_clk_i);
    rstn_i  <= 1'b1;
    apm_bit <= 1'($urandom);
    mng     <= 1'($urandom);
    wake_ev <= 1'($urandom);
    repeat (6) settle();
    chk(dev_st, FPSF_DEV_RST);
    chk(link_req, FPSF_LINK_L2);
    boot(1'b1);
    pm_write(0, FPSF_PS_D1);
    pm_write(0, FPSF_PS_D2);
    chk(dev_st, exp_dev());
    for (int f = 0; f < NF; f++) cmd_write(f, f[0], !f[0]);
    chk(f_en, act_mask());
    chk(mio, act_mask());
    chk(apm_en, apm_bit);
    @(posedge core_clk_i);
    wf_wr <= 1'b1;
    wf    <= 8'($urandom);
    wc_wr <= 1'b1;
    wc_apm <= 1'b1;
    @(posedge core_clk_i);
    wf_wr <= 1'b0;
    wc_wr <= 1'b0;
    settle();
    chk(apm_en, 1'b1);
    // driver has quiesced; in-flight reads still complete late
    @(posedge core_clk_i);
    issue <= 1'b1;
    @(posedge core_clk_i);
    issue <= 1'b0;
    for (int f = 0; f < NF; f++) begin
      pm_write(f, FPSF_PS_D3);
      chk(dev_st, exp_dev());
    end
    chk(mio, '0);
    chk(m_en, '0);
    chk(sched, '0);
    chk(link_req == FPSF_LINK_L1, 1'b0);
    repeat (12) settle();
    chk(link_req, FPSF_LINK_L1);
    chk(wf_o, wf);
    chk(phy_low, mng);
    for (int t = 0; t < 3; t++) begin
      @(posedge core_clk_i);
      rx_v    <= 4'h2;
      cfg_msg <= (t == 2);
      cpl     <= (t == 1);
      err_en  <= (t == 0);
      @(posedge core_clk_i);
      rx_v <= '0;
      watch(8);
      chk(seen[3:1], (t == 0) ? 3'h5 : (t == 1) ? 3'h2 : 3'h0);
      if (t == 0) chk(seen[4], 1'b1);
      err_en <= 1'b0;
      settle();
    end
    // clock enable low: a d0 write is lost and nothing moves
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    pm_wr    <= 4'h2;
    pm_st    <= FPSF_PS_D0;
    @(posedge core_clk_i);
    pm_wr <= '0;
    settle();
    chk(dev_st, exp_dev());
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    @(posedge core_clk_i);
    pm_wr <= 4'h4;
    pm_st <= FPSF_PS_D0;
    @(posedge core_clk_i);
    pm_wr <= '0;
    st[2] = 1;
    watch(6);
    chk(seen[0], 1'b1);
    chk(dev_st, exp_dev());
    chk(f_en, act_mask());
    @(posedge core_clk_i);
    frst_n <= 1'b0;
    repeat (2) settle();
    chk(dev_st, FPSF_DEV_RST);
    chk(wake_n, !wake_ev);
    boot(1'b0);
    pm_write(0, FPSF_PS_D3);
    chk(dev_st, FPSF_DEV_D0);
    @(posedge core_clk_i);
    aux    <= 1'b0;
    inband <= 1'b1;
    repeat (2) settle();
    chk(dev_st, FPSF_DEV_RST);
    chk(link_req, FPSF_LINK_L3);
    chk(wake_n, 1'b1);
    @(posedge core_clk_i);
    inband <= 1'b0;
    close_out();
  end
endmodule // fpsf_top_bench

/* File: hdl/fpsf_pkg.sv */
// Purpose: shared constants and types for the function power-state controller
// Assumes: one package for the single design file
// Notes:   power-state field encodings follow the standard power-management field
package fpsf_pkg;
  localparam int unsigned FPSF_NUM_FUNC = 4;
  localparam logic [1:0]  FPSF_PS_D0    = 2'h0;
  localparam logic [1:0]  FPSF_PS_D1    = 2'h1;
  localparam logic [1:0]  FPSF_PS_D2    = 2'h2;
  localparam logic [1:0]  FPSF_PS_D3    = 2'h3;
  // link state encoding on the link request output
  localparam logic [2:0]  FPSF_LINK_L0  = 3'h0;
  localparam logic [2:0]  FPSF_LINK_L1  = 3'h1;
  localparam logic [2:0]  FPSF_LINK_L2  = 3'h2;
  localparam logic [2:0]  FPSF_LINK_L3  = 3'h3;
  localparam logic [2:0]  FPSF_LINK_OFF = 3'h4;
  // device-state summary encoding, most active first
  localparam logic [1:0]  FPSF_DEV_D0   = 2'h0;
  localparam logic [1:0]  FPSF_DEV_D3H  = 2'h1;
  localparam logic [1:0]  FPSF_DEV_RST  = 2'h2;
  typedef enum logic [1:0] {
    FPSF_RESET_HELD,
    FPSF_UNINIT_D0,
    FPSF_ACTIVE_D0,
    FPSF_D3HOT
  } fpsf_state_t;
endpackage

/* File: hdl/fpsf_top.sv */
// Purpose: per-function power-state machines with a device-level summary
// Assumes: configuration writes arrive as one-cycle strobes on core_clk_i
// Notes:   d3cold is represented by the reset-held state; aux power picks L2 or L3
`timescale 1ns/1ns

module fpsf_top (
  // clock, reset, enable
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       clk_en_i,
  // pins
  input  wire logic                       fundamental_reset_n_i,
  input  wire logic                       aux_power_i,
  input  wire logic                       wake_event_i,
  // pcie core events
  input  wire logic                       inband_reset_i,
  input  wire logic                       link_in_l0_i,
  input  wire logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] tlp_rx_valid_i,
  input  wire logic                       tlp_is_cfg_msg_i,
  input  wire logic                       tlp_is_cpl_i,
  input  wire logic                       err_report_en_i,
  input  wire logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] tlp_outstanding_i,
  // configuration writes per function
  input  wire logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] pm_wr_i,
  input  wire logic [1:0]                 pm_state_i,
  input  wire logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] cmd_wr_i,
  input  wire logic                       cmd_mem_en_i,
  input  wire logic                       cmd_io_en_i,
  // eeprom loader
  input  wire logic                       eeprom_busy_i,
  input  wire logic                       eeprom_done_i,
  input  wire logic                       pm_enable_bit_i,
  input  wire logic                       apm_wake_default_bit_i,
  input  wire logic                       mng_or_wake_needed_i,
  // wake registers written by software
  input  wire logic                       wake_control_wr_i,
  input  wire logic                       wake_control_apm_i,
  input  wire logic                       wake_filter_control_wr_i,
  input  wire logic [7:0]                 wake_filter_control_i,
  // outputs
  output logic [1:0]                      device_state_o,
  output logic [2:0]                      link_req_o,
  output logic                            link_enable_o,
  output logic                            eeprom_load_o,
  output logic                            phy_reset_o,
  output logic                            phy_low_speed_o,
  output logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] func_enable_o,
  output logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] mem_io_en_o,
  output logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] master_en_o,
  output logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] tlp_sched_en_o,
  output logic [fpsf_pkg::FPSF_NUM_FUNC-1:0] rx_discard_o,
  output logic                            ur_o,
  output logic                            uc_o,
  output logic                            err_msg_o,
  output logic                            apm_wake_en_o,
  output logic [7:0]                      wake_filter_o,
  output logic                            sideband_wake_request_n_o,
  output logic                            pm_disabled_o
);
  import fpsf_pkg::*;
  localparam int unsigned NF = FPSF_NUM_FUNC;

  // reset release and pin synchronisers
  logic       rst_s1_q, rst_n_q;
  // the wake source is a pin as well, so it rides in the same synchroniser
  logic [2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else if (clk_en_i) begin
      pin_s1_q <= {wake_event_i, aux_power_i, fundamental_reset_n_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire perst_n  = pin_s2_q[0];
  wire aux_pwr  = pin_s2_q[1];
  wire wake_pin = pin_s2_q[2];
  wire any_rst  = !perst_n || inband_reset_i;

  // eeprom load phase: load runs after reset release, link only after it
  logic loading_q, loaded_q;
  wire  load_start = !any_rst && !loading_q && !loaded_q;
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      loading_q <= 1'b0;
      loaded_q  <= 1'b0;
    end else if (clk_en_i) begin
      if (any_rst) begin
        loading_q <= 1'b0;
        loaded_q  <= 1'b0;
      end else if (load_start) begin
        loading_q <= 1'b1;
      end else if (loading_q && eeprom_done_i) begin
        loading_q <= 1'b0;
        loaded_q  <= 1'b1;
      end
    end
  end

  // pm disable strap is taken once the load has completed
  logic pm_en_q;
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) pm_en_q <= 1'b1;
    else if (clk_en_i && loading_q && eeprom_done_i) pm_en_q <= pm_enable_bit_i;
  end

  // per-function state machines
  fpsf_state_t st_q [NF];
  fpsf_state_t st_d [NF];
  logic [NF-1:0] mem_io_q, in_d3, in_d0, in_d0u, enter_d3, exit_d3;
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_fn
      wire wr_d0  = pm_wr_i[g] && pm_state_i == FPSF_PS_D0;
      wire wr_d3  = pm_wr_i[g] && pm_state_i == FPSF_PS_D3 && pm_en_q;
      wire cmd_on = cmd_wr_i[g] && (cmd_mem_en_i || cmd_io_en_i);
      always_comb begin
        st_d[g] = st_q[g];
        // D1/D2 writes match no transition and fall through unchanged
        unique case (st_q[g])
          FPSF_RESET_HELD: if (!any_rst) st_d[g] = FPSF_UNINIT_D0;
          FPSF_UNINIT_D0:  if (wr_d3) st_d[g] = FPSF_D3HOT;
                           else if (cmd_on && loaded_q) st_d[g] = FPSF_ACTIVE_D0;
          FPSF_ACTIVE_D0:  if (wr_d3) st_d[g] = FPSF_D3HOT;
          FPSF_D3HOT:      if (wr_d0) st_d[g] = FPSF_UNINIT_D0;
        endcase
        if (any_rst) st_d[g] = FPSF_RESET_HELD;
      end
      always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) st_q[g] <= FPSF_RESET_HELD;
        else if (clk_en_i) st_q[g] <= st_d[g];
      end
      assign in_d3[g]    = st_q[g] == FPSF_D3HOT;
      assign in_d0[g]    = st_q[g] == FPSF_ACTIVE_D0 || st_q[g] == FPSF_UNINIT_D0;
      assign in_d0u[g]   = st_q[g] == FPSF_UNINIT_D0;
      assign enter_d3[g] = st_d[g] == FPSF_D3HOT && !in_d3[g];
      assign exit_d3[g]  = in_d3[g] && st_d[g] != FPSF_D3HOT;
      // command enables: D3hot entry clears them
      always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) mem_io_q[g] <= 1'b0;
        else if (clk_en_i) begin
          if (any_rst || enter_d3[g]) mem_io_q[g] <= 1'b0;
          else if (cmd_wr_i[g]) mem_io_q[g] <= cmd_mem_en_i || cmd_io_en_i;
        end
      end
    end
  endgenerate

  // device-level summary and link mapping
  wire       any_d0  = |in_d0;
  wire       any_d3  = |in_d3;
  wire [1:0] dev_d   = any_d0 ? FPSF_DEV_D0 : any_d3 ? FPSF_DEV_D3H : FPSF_DEV_RST;
  wire [NF-1:0] quiet = in_d3 & ~tlp_outstanding_i;
  wire       d3_quiet = any_d3 && !any_d0 && (&(quiet | ~in_d3));
  wire       rx_bad   = |(tlp_rx_valid_i & in_d3);
  wire       rx_ur    = rx_bad && !tlp_is_cfg_msg_i && !tlp_is_cpl_i;
  wire       rx_uc    = rx_bad && tlp_is_cpl_i;
  logic      err_pend_q;
  wire [2:0] link_d = any_rst        ? (aux_pwr ? FPSF_LINK_L2 : FPSF_LINK_L3) :
                      !loaded_q      ? FPSF_LINK_OFF :
                      err_pend_q     ? FPSF_LINK_L0 :
                      d3_quiet       ? FPSF_LINK_L1 : FPSF_LINK_L0;

  // error message waits for the link to reach L0
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) err_pend_q <= 1'b0;
    else if (clk_en_i) begin
      if (any_rst) err_pend_q <= 1'b0;
      else if ((rx_ur || rx_uc) && err_report_en_i) err_pend_q <= 1'b1;
      else if (link_in_l0_i) err_pend_q <= 1'b0;
    end
  end

  // wake settings: frozen in D3hot, APM kept until software clears it or the next eeprom load reloads it
  logic       apm_q;
  logic [7:0] filt_q;
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      apm_q  <= 1'b0;
      filt_q <= 8'h00;
    end else if (clk_en_i) begin
      if (loading_q && eeprom_done_i) begin
        apm_q  <= apm_wake_default_bit_i;
        filt_q <= 8'h00;
      end else if (!any_d3 && pm_en_q) begin
        if (wake_control_wr_i) apm_q <= wake_control_apm_i;
        if (wake_filter_control_wr_i) filt_q <= wake_filter_control_i;
      end
    end
  end
  wire wake_armed = (apm_q || |filt_q) && wake_pin && !any_d0;

  // registered outputs
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      device_state_o <= FPSF_DEV_RST;
      link_req_o     <= FPSF_LINK_OFF;
      link_enable_o  <= 1'b0;
      eeprom_load_o  <= 1'b0;
      phy_reset_o    <= 1'b1;
      phy_low_speed_o <= 1'b0;
      func_enable_o  <= '0;
      mem_io_en_o    <= '0;
      master_en_o    <= '0;
      tlp_sched_en_o <= '0;
      rx_discard_o   <= '0;
      ur_o           <= 1'b0;
      uc_o           <= 1'b0;
      err_msg_o      <= 1'b0;
      apm_wake_en_o  <= 1'b0;
      wake_filter_o  <= 8'h00;
      sideband_wake_request_n_o <= 1'b1;
      pm_disabled_o  <= 1'b0;
    end else if (clk_en_i) begin
      device_state_o <= dev_d;
      link_req_o     <= link_d;
      link_enable_o  <= loaded_q && !any_rst;
      eeprom_load_o  <= loading_q;
      phy_reset_o    <= any_rst || loading_q || eeprom_busy_i;
      phy_low_speed_o <= any_d3 && !any_d0 && mng_or_wake_needed_i;
      func_enable_o  <= {NF{1'b0}} | (mem_io_q & ~in_d3 & ~in_d0u);
      mem_io_en_o    <= mem_io_q;
      master_en_o    <= mem_io_q & ~in_d3 & ~in_d0u;
      tlp_sched_en_o <= ~in_d3;
      rx_discard_o   <= exit_d3;
      ur_o           <= rx_ur;
      uc_o           <= rx_uc;
      err_msg_o      <= err_pend_q && link_in_l0_i;
      apm_wake_en_o  <= apm_q;
      wake_filter_o  <= filt_q;
      sideband_wake_request_n_o <= !(wake_armed && any_rst && aux_pwr);
      pm_disabled_o  <= !pm_en_q;
    end
  end

  // assertions: function state transitions
  a_reset_held: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && any_rst |=> st_q[0] == FPSF_RESET_HELD)
    else $error("reset did not force reset-held");
  a_d0_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && st_q[2] == FPSF_D3HOT && pm_wr_i[2] && pm_state_i == FPSF_PS_D0
    && !any_rst |=> st_q[2] == FPSF_UNINIT_D0)
    else $error("d0 write did not leave d3hot");
  a_d3_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && in_d0[0] && pm_wr_i[0] && pm_state_i == FPSF_PS_D3 && pm_en_q
    && !any_rst |=> st_q[0] == FPSF_D3HOT)
    else $error("d3 write did not enter d3hot");
  a_active_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && in_d0u[0] && cmd_wr_i[0] && (cmd_mem_en_i || cmd_io_en_i) && loaded_q
    && !pm_wr_i[0] && !any_rst |=> st_q[0] == FPSF_ACTIVE_D0)
    else $error("command enable did not activate");
  a_d1_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && pm_wr_i[0] && (pm_state_i == FPSF_PS_D1 || pm_state_i == FPSF_PS_D2)
    && !any_rst && !cmd_wr_i[0] && st_q[0] != FPSF_RESET_HELD |=> $stable(st_q[0]))
    else $error("d1 or d2 write changed state");
  a_pm_off_no_d3: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && !pm_en_q && !in_d3[0] |=> !in_d3[0])
    else $error("d3hot entered with power management off");
  a_en_freeze: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    !clk_en_i |=> $stable(st_q[0]) && $stable(device_state_o) && $stable(link_req_o))
    else $error("state moved with clock enable low");

  // assertions: d3hot side effects
  a_d3_link_l1: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && d3_quiet && !err_pend_q && loaded_q && !any_rst
    |=> link_req_o == FPSF_LINK_L1)
    else $error("d3hot did not request L1");
  a_d3_clr_en: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && enter_d3[0] |=> !mem_io_q[0] ##1 (!master_en_o[0] || !$past(clk_en_i)))
    else $error("enables survive d3 entry");
  a_d3_no_master: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && in_d3[1] |=> !master_en_o[1])
    else $error("master enabled in d3hot");
  a_d3_no_sched: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && in_d3[1] |=> !tlp_sched_en_o[1])
    else $error("tlp scheduling left on in d3hot");
  a_sched_d0: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && !in_d3[1] |=> tlp_sched_en_o[1])
    else $error("tlp scheduling off outside d3hot");
  a_d3_filt_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && any_d3 && !(loading_q && eeprom_done_i) |=> $stable(filt_q))
    else $error("wake filters changed in d3hot");
  a_ur_report: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && (tlp_rx_valid_i & in_d3) != '0 && !tlp_is_cfg_msg_i && !tlp_is_cpl_i
    |=> ur_o)
    else $error("unsupported request not flagged");
  a_uc_report: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && (tlp_rx_valid_i & in_d3) != '0 && tlp_is_cpl_i |=> uc_o)
    else $error("unexpected completion not flagged");
  a_ur_no_cfg: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && tlp_is_cfg_msg_i && !tlp_is_cpl_i |=> !ur_o && !uc_o)
    else $error("config or message request flagged");
  a_err_link: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && err_pend_q && loaded_q && !any_rst |=> link_req_o == FPSF_LINK_L0)
    else $error("pending error did not request L0");
  a_err_msg: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && err_pend_q && link_in_l0_i |=> err_msg_o)
    else $error("error message not sent in L0");
  a_rx_discard: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && exit_d3[0] |=> rx_discard_o[0])
    else $error("held receive packets not discarded on exit");
  a_low_speed: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && any_d3 && !any_d0 && mng_or_wake_needed_i |=> phy_low_speed_o)
    else $error("phy kept at full speed in d3hot");

  // assertions: reset, load and device summary
  a_phy_in_rst: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && loading_q |=> phy_reset_o)
    else $error("phy released during eeprom load");
  a_link_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && !loaded_q |=> !link_enable_o)
    else $error("link enabled before eeprom load");
  a_load_link: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && loaded_q && !any_rst |=> link_enable_o)
    else $error("link not enabled after eeprom load");
  a_apm_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && loading_q && eeprom_done_i |=> apm_q == $past(apm_wake_default_bit_i)
    && filt_q == 8'h00)
    else $error("wake settings not set up by the load");
  a_pm_disabled: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i |=> pm_disabled_o == !$past(pm_en_q))
    else $error("pm disable flag does not follow the strap");
  a_dev_d0: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && any_d0 |=> device_state_o == FPSF_DEV_D0)
    else $error("device state not d0 with a d0 function");
  a_d0_no_l1: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && any_d0 && loaded_q && !any_rst |=> link_req_o == FPSF_LINK_L0)
    else $error("link left L0 with a d0 function");
  a_func_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && st_q[0] == FPSF_ACTIVE_D0 && mem_io_q[0] |=> func_enable_o[0])
    else $error("active function not enabled");
  a_wake_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && !any_rst |=> sideband_wake_request_n_o)
    else $error("wake request outside reset-held");
  a_l3_noaux: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    clk_en_i && any_rst && !aux_pwr |=> link_req_o == FPSF_LINK_L3)
    else $error("reset without aux power not mapped to L3");

  // covers for the main scenarios
  c_active: cover property (@(posedge core_clk_i) st_q[0] == FPSF_ACTIVE_D0);
  c_d3: cover property (@(posedge core_clk_i) in_d3[2] ##1 st_q[2] == FPSF_UNINIT_D0);
  c_err: cover property (@(posedge core_clk_i) err_msg_o);
  c_l1: cover property (@(posedge core_clk_i) link_req_o == FPSF_LINK_L1);
  c_freeze: cover property (@(posedge core_clk_i) !clk_en_i ##1 clk_en_i);
endmodule // fpsf_top
